// ---- verilog/gpg_consts.vh ----
/*
 constants for the eight-pin port group control block: register offsets,
 field positions, reset values and filter timing.
 assumes inclusion by bare name from the design file.
*/
`ifndef GPG_CONSTS_VH
`define GPG_CONSTS_VH

// ----------------------------------------
// register offsets (word index on the port)
// ----------------------------------------
`define GPG_OFS_DATA        3'h0
`define GPG_OFS_IO_ENABLE   3'h1
`define GPG_OFS_PULL_CTRL   3'h2
`define GPG_OFS_IRQ_FLAGS   3'h3
`define GPG_OFS_IRQ_CTRL    3'h4
`define GPG_OFS_DEBOUNCE    3'h5
`define GPG_OFS_MODE_SEL    3'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define GPG_HI_MSB          15
`define GPG_HI_LSB          8
`define GPG_LO_MSB          7
`define GPG_LO_LSB          0

// ----------------------------------------
// reset values
// ----------------------------------------
`define GPG_RST_REG16       16'h0000
`define GPG_RST_BYTE        8'h00

// ----------------------------------------
// filter timing
// ----------------------------------------
`define GPG_FILTER_SAMPLES  2

`endif

// ---- verilog/gpg_port.v ----
/*
 one eight-pin general-purpose port group: output drive, enables, hi-z,
 readback, pull control, edge interrupt flags, debounce and mode select.
 assumes pins may be asynchronous to core_clk_i, the register port never waits,
 and port_filter_clock_i is a synchronous enable-like tick from the clock tree.
*/
// Our own choices: the register addresses and the strobed register port.
// Function
// - output enable drives pin with data
// - peripheral pin ignores output data bit
// - data low byte reads gated pin levels
// - peripheral pin hides input from software
// - enable register: input high, output low
// - output disabled releases pin to hi-z
// - in and out enabled reads driven level
// - enables ignored for peripheral pins
// - pull select up one, down zero
// - pull only while output disabled
// - pull settings ignored for peripheral pins
// - flags write-one-clear, upper bits read zero
// - edge select one falling, zero rising
// - per-pin interrupt enable bits
// - debounce enable routes through filter
// - mode bit one selects peripheral
// - control registers act only in gpio mode
// - mode bit zero selects gpio
// - selected edge sets pin flag
// - request only for enabled set flag
// - filter drops pulses under one-two ticks
`include "gpg_consts.vh"
`default_nettype none

module gpg_port #(
	parameter integer PINS = 8
) (
	input  wire            core_clk_i,
	input  wire            rst_i,
	input  wire [2:0]      reg_addr_i,
	input  wire [15:0]     reg_wdata_i,
	input  wire            reg_write_i,
	input  wire            reg_read_i,
	output reg  [15:0]     reg_rdata_o,
	input  wire            port_filter_clock_i,
	input  wire [PINS-1:0] pin_i,
	output reg  [PINS-1:0] pin_o,
	output reg  [PINS-1:0] pin_oe_n_o,
	output reg  [PINS-1:0] pull_up_o,
	output reg  [PINS-1:0] pull_down_o,
	output reg  [PINS-1:0] periph_in_o,
	input  wire [PINS-1:0] periph_out_i,
	input  wire [PINS-1:0] periph_oe_i,
	input  wire [PINS-1:0] periph_pull_up_i,
	input  wire [PINS-1:0] periph_pull_down_i,
	output reg             irq_o
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg  [PINS-1:0] pin_output_value_q;
	reg  [PINS-1:0] pin_input_enable_q;
	reg  [PINS-1:0] pin_output_enable_q;
	reg  [PINS-1:0] pull_direction_select_q;
	reg  [PINS-1:0] pull_resistor_enable_q;
	reg  [PINS-1:0] irq_edge_select_q;
	reg  [PINS-1:0] pin_irq_enable_q;
	reg  [PINS-1:0] debounce_enable_q;
	reg  [PINS-1:0] pin_function_select_q;
	reg  [PINS-1:0] in_prev_q;
	reg  [PINS-1:0] pin_input_value_q;
	reg  [15:0]     rdata_d;

	wire [PINS-1:0] gpio_mode;
	wire [PINS-1:0] pin_cond;
	wire [PINS-1:0] in_gated;
	wire [PINS-1:0] edge_hit;
	wire [PINS-1:0] out_en;
	wire [PINS-1:0] out_val;
	wire [PINS-1:0] pull_on;
	wire            wr_flags;
	wire [PINS-1:0] sync2_q;
	wire [PINS-1:0] filt_q;
	wire [PINS-1:0] pin_irq_flag_q;
	wire [PINS-1:0] flag_set;
	wire [PINS-1:0] flag_clr;

	assign gpio_mode = ~pin_function_select_q;

	assign pin_cond = (debounce_enable_q & filt_q) | (~debounce_enable_q & sync2_q);

	assign in_gated = pin_cond & pin_input_enable_q & gpio_mode;

	assign edge_hit = (irq_edge_select_q & in_prev_q & ~in_gated)
		| (~irq_edge_select_q & ~in_prev_q & in_gated);

	assign out_en  = (gpio_mode & pin_output_enable_q) | (~gpio_mode & periph_oe_i);
	assign out_val = (gpio_mode & pin_output_value_q) | (~gpio_mode & periph_out_i);
	assign pull_on = gpio_mode & pull_resistor_enable_q & ~pin_output_enable_q;

	assign wr_flags = reg_write_i && (reg_addr_i == `GPG_OFS_IRQ_FLAGS);

	// ----------------------------------------
	// flag set and clear
	// ----------------------------------------
	// only gpio pins raise causes
	assign flag_set = edge_hit & gpio_mode;
	assign flag_clr = {PINS{wr_flags}} & reg_wdata_i[`GPG_LO_MSB:`GPG_LO_LSB];

	// ----------------------------------------
	// synchroniser, debounce filter and flags
	// ----------------------------------------
	gpg_sync #(
		.WIDTH(PINS)
	) i_sync (
		.core_clk_i(core_clk_i),
		.rst_i     (rst_i),
		.async_i   (pin_i),
		.sync_o    (sync2_q)
	);

	genvar g;
	generate
		for (g = 0; g < PINS; g = g + 1)
		begin : g_pin
			gpg_filter #(
				.SAMPLES(`GPG_FILTER_SAMPLES)
			) i_filt (
				.core_clk_i(core_clk_i),
				.rst_i     (rst_i),
				.tick_i    (port_filter_clock_i),
				.level_i   (sync2_q[g]),
				.level_o   (filt_q[g])
			);
			gpg_flag i_flag (
				.core_clk_i(core_clk_i),
				.rst_i     (rst_i),
				.set_i     (flag_set[g]),
				.clear_i   (flag_clr[g]),
				.flag_o    (pin_irq_flag_q[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			pin_output_value_q      <= `GPG_RST_BYTE;
			pin_input_enable_q      <= `GPG_RST_BYTE;
			pin_output_enable_q     <= `GPG_RST_BYTE;
			pull_direction_select_q <= `GPG_RST_BYTE;
			pull_resistor_enable_q  <= `GPG_RST_BYTE;
			irq_edge_select_q       <= `GPG_RST_BYTE;
			pin_irq_enable_q        <= `GPG_RST_BYTE;
			debounce_enable_q       <= `GPG_RST_BYTE;
			pin_function_select_q   <= `GPG_RST_BYTE;
			in_prev_q               <= `GPG_RST_BYTE;
			pin_input_value_q       <= `GPG_RST_BYTE;
		end
		else
		begin
			in_prev_q         <= in_gated;
			pin_input_value_q <= in_gated;
			if (reg_write_i)
			begin
				case (reg_addr_i)
					`GPG_OFS_DATA:
						pin_output_value_q <= reg_wdata_i[`GPG_HI_MSB:`GPG_HI_LSB];
					`GPG_OFS_IO_ENABLE:
					begin
						pin_input_enable_q  <= reg_wdata_i[`GPG_HI_MSB:`GPG_HI_LSB];
						pin_output_enable_q <= reg_wdata_i[`GPG_LO_MSB:`GPG_LO_LSB];
					end
					`GPG_OFS_PULL_CTRL:
					begin
						pull_direction_select_q <= reg_wdata_i[`GPG_HI_MSB:`GPG_HI_LSB];
						pull_resistor_enable_q  <= reg_wdata_i[`GPG_LO_MSB:`GPG_LO_LSB];
					end
					`GPG_OFS_IRQ_CTRL:
					begin
						irq_edge_select_q <= reg_wdata_i[`GPG_HI_MSB:`GPG_HI_LSB];
						pin_irq_enable_q  <= reg_wdata_i[`GPG_LO_MSB:`GPG_LO_LSB];
					end
					`GPG_OFS_DEBOUNCE:
						debounce_enable_q <= reg_wdata_i[`GPG_LO_MSB:`GPG_LO_LSB];
					`GPG_OFS_MODE_SEL:
						pin_function_select_q <= reg_wdata_i[`GPG_LO_MSB:`GPG_LO_LSB];
					default:
						pin_output_value_q <= pin_output_value_q;
				endcase
			end
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always @*
	begin
		rdata_d = `GPG_RST_REG16;
		case (reg_addr_i)
			`GPG_OFS_DATA:
				rdata_d = {pin_output_value_q, pin_input_value_q};
			`GPG_OFS_IO_ENABLE:
				rdata_d = {pin_input_enable_q, pin_output_enable_q};
			`GPG_OFS_PULL_CTRL:
				rdata_d = {pull_direction_select_q, pull_resistor_enable_q};
			`GPG_OFS_IRQ_FLAGS:
				rdata_d = {`GPG_RST_BYTE, pin_irq_flag_q};
			`GPG_OFS_IRQ_CTRL:
				rdata_d = {irq_edge_select_q, pin_irq_enable_q};
			`GPG_OFS_DEBOUNCE:
				rdata_d = {`GPG_RST_BYTE, debounce_enable_q};
			`GPG_OFS_MODE_SEL:
				rdata_d = {`GPG_RST_BYTE, pin_function_select_q};
			default:
				rdata_d = `GPG_RST_REG16;
		endcase
	end

	// ----------------------------------------
	// outputs, all registered
	// ----------------------------------------
	always @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			reg_rdata_o <= `GPG_RST_REG16;
			pin_o       <= `GPG_RST_BYTE;
			pin_oe_n_o  <= {PINS{1'b1}};
			pull_up_o   <= `GPG_RST_BYTE;
			pull_down_o <= `GPG_RST_BYTE;
			periph_in_o <= `GPG_RST_BYTE;
			irq_o       <= 1'b0;
		end
		else
		begin
			reg_rdata_o <= reg_read_i ? rdata_d : `GPG_RST_REG16;
			pin_o       <= out_val;
			pin_oe_n_o  <= ~out_en;
			pull_up_o   <= (pull_on & pull_direction_select_q)
				| (~gpio_mode & periph_pull_up_i);
			pull_down_o <= (pull_on & ~pull_direction_select_q)
				| (~gpio_mode & periph_pull_down_i);
			// peripheral sees raw synchronised level
			periph_in_o <= sync2_q;
			irq_o       <= |(pin_irq_flag_q & pin_irq_enable_q & gpio_mode);
		end
	end

endmodule // gpg_port

module gpg_sync #(
	parameter integer WIDTH = 8
) (
	input  wire             core_clk_i,
	input  wire             rst_i,
	input  wire [WIDTH-1:0] async_i,
	output reg  [WIDTH-1:0] sync_o
);

	// ----------------------------------------
	// two-stage synchroniser
	// ----------------------------------------
	reg  [WIDTH-1:0] stage1_q;

	// first stage feeds only the second stage
	always @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			stage1_q <= {WIDTH{1'b0}};
			sync_o   <= {WIDTH{1'b0}};
		end
		else
		begin
			stage1_q <= async_i;
			sync_o   <= stage1_q;
		end
	end

endmodule // gpg_sync

module gpg_filter #(
	parameter integer SAMPLES = `GPG_FILTER_SAMPLES
) (
	input  wire core_clk_i,
	input  wire rst_i,
	input  wire tick_i,
	input  wire level_i,
	output reg  level_o
);

	// ----------------------------------------
	// debounce counter
	// ----------------------------------------
	// limitation: two-bit count, so SAMPLES up to four
	reg  [1:0] cnt_q;

	// level must hold over filter ticks
	always @(posedge core_clk_i)
	begin
		if (rst_i)
		begin
			cnt_q   <= 2'h0;
			level_o <= 1'b0;
		end
		else if (level_i == level_o)
			// any return to the old level restarts it
			cnt_q <= 2'h0;
		else if (tick_i)
		begin
			if (cnt_q == SAMPLES - 1)
			begin
				level_o <= level_i;
				cnt_q   <= 2'h0;
			end
			else
				cnt_q <= cnt_q + 2'h1;
		end
	end

endmodule // gpg_filter

module gpg_flag (
	input  wire core_clk_i,
	input  wire rst_i,
	input  wire set_i,
	input  wire clear_i,
	output reg  flag_o
);

	// ----------------------------------------
	// sticky cause flag
	// ----------------------------------------
	// set wins so no edge is lost to a clear
	always @(posedge core_clk_i)
	begin
		if (rst_i)
			flag_o <= 1'b0;
		else if (set_i)
			flag_o <= 1'b1;
		else if (clear_i)
			flag_o <= 1'b0;
	end

endmodule // gpg_flag

`default_nettype wire

// ---- testbench/gpg_port_asserts.sv ----
/*
 checker: port relations of gpg_port.
 assumes a bind to gpg_port, sync reset.
*/
`default_nettype none
module gpg_port_asserts #(
	parameter integer PINS = 8
) (
	input wire logic            core_clk_i,
	input wire logic            rst_i,
	input wire logic [2:0]      reg_addr_i,
	input wire logic [15:0]     reg_wdata_i,
	input wire logic            reg_write_i,
	input wire logic            reg_read_i,
	input wire logic [15:0]     reg_rdata_o,
	input wire logic [PINS-1:0] pin_o,
	input wire logic [PINS-1:0] pin_oe_n_o,
	input wire logic [PINS-1:0] pull_up_o,
	input wire logic [PINS-1:0] pull_down_o,
	input wire logic [PINS-1:0] periph_oe_i,
	input wire logic            irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	AST_RD_IDLE: assert property (!$past(reg_read_i) |-> reg_rdata_o == 16'h0000)
		else $error("rdata not idle");
	AST_RSVD: assert property ($past(reg_read_i) && $past(reg_addr_i) inside {3'h3, 3'h5, 3'h6}
		|-> reg_rdata_o[15:8] == 8'h00) else $error("reserved bits");
	AST_UNMAP: assert property ($past(reg_read_i) && $past(reg_addr_i) == 3'h7
		|-> reg_rdata_o == 16'h0000) else $error("unmapped read");
	AST_DRIVE: assert property (reg_write_i && reg_addr_i == 3'h0 |-> ##2 ((pin_o ^
		$past(reg_wdata_i[15:8], 2)) & ~pin_oe_n_o & ~periph_oe_i) == 8'h00) else $error("drive");
	AST_HIZ: assert property (reg_write_i && reg_addr_i == 3'h1 |-> ##2 (~pin_oe_n_o &
		~$past(reg_wdata_i[7:0], 2) & ~periph_oe_i) == 8'h00) else $error("hi-z");
	AST_PULL_OFF: assert property (((pull_up_o | pull_down_o) & ~pin_oe_n_o) == 8'h00)
		else $error("pull on driven pin");
	AST_PULL_SEL: assert property (reg_write_i && reg_addr_i == 3'h2 |-> ##2
		((pull_up_o & ~$past(reg_wdata_i[15:8], 2)) | (pull_down_o & $past(reg_wdata_i[15:8], 2)))
		== 8'h00) else $error("pull select");
	AST_IRQ_OFF: assert property (reg_write_i && reg_addr_i == 3'h4 &&
		reg_wdata_i[7:0] == 8'h00 |-> ##2 !irq_o [*2]) else $error("irq not masked");
	cover property ($rose(irq_o));
	cover property (pull_up_o != 8'h00 && pull_down_o != 8'h00);
	cover property ($past(reg_read_i) && reg_rdata_o != 16'h0000);
endmodule // gpg_port_asserts
bind gpg_port gpg_port_asserts #(.PINS(PINS)) i_chk (.*);
`default_nettype wire

// ---- testbench/gpg_pin_model.sv ----
/*
 pads outside the port: port drive, an external driver, pulls.
 assumes the bench clock; a loose pad toggles, no value is implied.
*/
`default_nettype none
module gpg_pin_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] drv_i,
	input  wire logic [7:0] oe_n_i,
	input  wire logic [7:0] pu_i,
	input  wire logic [7:0] pd_i,
	input  wire logic [7:0] ext_en_i,
	input  wire logic [7:0] ext_val_i,
	output wire logic [7:0] pad_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] float_q = 8'h00;
	always @(posedge clk_i) float_q <= ~float_q;
	assign pad_o = (~oe_n_i & drv_i) | (oe_n_i & ext_en_i & ext_val_i)
		| (oe_n_i & ~ext_en_i & (pu_i | (~pd_i & float_q)));
endmodule // gpg_pin_model
`default_nettype wire

// ---- testbench/gpio_port_group_control_bench.sv ----
/*
 self-checking bench: registers, pads, irq, modes.
 assumes gpg_port, its checker and the pad model.
*/
`default_nettype none
module gpio_port_group_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, irq;
	logic [2:0] addr = 3'h0;
	logic [15:0] wd = 16'h0000, rd;
	logic [7:0] pin_i, pin_o, oe_n, pu, pd, p_in, p_out = 8'h00, p_oe = 8'h00;
	logic [7:0] ext_en = 8'h00, ext_v = 8'h00;
	int fail_count = 0, checks_done = 0;
	always #4 clk = ~clk;
	gpg_port i_dut (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_write_i(we), .reg_read_i(re), .reg_rdata_o(rd), .port_filter_clock_i(1'b1),
		.pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(oe_n), .pull_up_o(pu), .pull_down_o(pd),
		.periph_in_o(p_in), .periph_out_i(p_out), .periph_oe_i(p_oe),
		.periph_pull_up_i(8'h00), .periph_pull_down_i(8'h00), .irq_o(irq));
	gpg_pin_model i_pads (.clk_i(clk), .drv_i(pin_o), .oe_n_i(oe_n), .pu_i(pu), .pd_i(pd),
		.ext_en_i(ext_en), .ext_val_i(ext_v), .pad_o(pin_i));
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rdc(input string n, input logic [2:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 chk(n, rd, e);
	endtask
	task automatic settle;
		repeat (8) @(posedge clk);
	endtask
	task automatic pads(input logic [7:0] en, input logic [7:0] v);
		@(posedge clk);
		ext_en <= en;
		ext_v <= v;
		settle;
	endtask
	task automatic t_reset;
		for (int a = 0; a < 8; a++)
			rdc("reset", 3'(a), 16'h0000);
		chk("oe_n", {8'h00, oe_n}, 16'h00FF);
	endtask
	task automatic t_out;
		wr(3'h0, 16'hA500);
		wr(3'h1, 16'hFF0F);
		pads(8'hF0, 8'h30);
		chk("drive", {oe_n, pin_o & ~oe_n}, 16'hF005);
		rdc("readback", 3'h0, 16'hA535);
		wr(3'h0, 16'h5A00);
		settle;
		chk("pads", {8'h00, pin_i}, 16'h003A);
		wr(3'h1, 16'h000F);
		settle;
		rdc("input off", 3'h0, 16'h5A00);
	endtask
	task automatic t_pull;
		wr(3'h2, 16'hC0FF);
		settle;
		chk("pulls", {pu, pd}, 16'hC030);
		wr(3'h2, 16'hC07F);
		settle;
		chk("pull en", {pu, pd}, 16'h4030);
		rdc("pull reg", 3'h2, 16'hC07F);
	endtask
	task automatic t_irq;
		pads(8'hFF, 8'h00);
		wr(3'h1, 16'hFF00);
		wr(3'h3, 16'hFFFF);
		wr(3'h4, 16'h0201);
		rdc("clear", 3'h3, 16'h0000);
		pads(8'hFF, 8'h03);
		rdc("rise", 3'h3, 16'h0001);
		chk("irq on", {15'h0000, irq}, 16'h0001);
		pads(8'hFF, 8'h00);
		wr(3'h3, 16'hFF00);
		rdc("fall", 3'h3, 16'h0003);
		wr(3'h3, 16'h0001);
		settle;
		rdc("w1c", 3'h3, 16'h0002);
		chk("irq off", {15'h0000, irq}, 16'h0000);
		wr(3'h4, 16'h0000);
		wr(3'h3, 16'h00FF);
	endtask
	task automatic t_mode;
		@(posedge clk);
		p_oe <= 8'h01;
		p_out <= 8'h01;
		wr(3'h6, 16'hFF01);
		settle;
		chk("periph", {13'h0000, oe_n[0], pin_o[0], pd[0]}, 16'h0002);
		rdc("hidden", 3'h0, 16'h5A00);
		rdc("mode reg", 3'h6, 16'h0001);
		wr(3'h6, 16'h0000);
		settle;
		chk("gpio", {14'h0000, oe_n[0], pd[0]}, 16'h0003);
		wr(3'h5, 16'hFFFF);
		rdc("filter reg", 3'h5, 16'h00FF);
	endtask
	task automatic glitch;
		@(posedge clk);
		ext_v <= 8'h04;
		@(posedge clk);
		ext_v <= 8'h00;
		settle;
	endtask
	task automatic t_filter;
		wr(3'h3, 16'h00FF);
		glitch;
		rdc("glitch", 3'h3, 16'h0000);
		pads(8'hFF, 8'h04);
		rdc("held", 3'h3, 16'h0004);
		chk("periph in", {8'h00, p_in}, 16'h0004);
		pads(8'hFF, 8'h00);
		wr(3'h3, 16'h00FF);
		wr(3'h5, 16'h0000);
		glitch;
		rdc("bypass", 3'h3, 16'h0004);
	endtask
	initial
	begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_out;
		t_pull;
		t_irq;
		t_mode;
		t_filter;
		stop_test;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		stop_test;
	end
endmodule // gpio_port_group_control_bench
`default_nettype wire
